/* rtl/spirc_cmd_decoder.sv */
// Serial command decoder for reset and register access commands
// How it works
// - Opcode 00 is accepted and changes no register.
// - Reset is 66 then 99, each a lone opcode byte.
// - 99 acts only if the command just before was 66.
// - 9F returns one manufacturer byte then two device bytes.
// - 5A takes three address bytes, MSB first, then streams table data.
// - 05 returns the status byte.
// - 15 returns the configuration byte.
// - 01 writes status, and configuration if a second byte follows.
// - 71 takes four address bytes then returns one second-configuration byte.
// - 72 takes four address bytes and one byte stored at that location.
// - 16 returns the fast-boot register, one to four bytes.
// - 17 with exactly four bytes replaces the fast-boot register.
// - 18 erases the fast-boot register.
// - 2B returns the security byte.
// - 2F sets the lock-down bit, which only the hardware reset clears.
// - 2C writes and 2D reads one lock register byte.
`include "spirc_defines.svh"
module spirc_cmd_decoder #(
  parameter logic [7:0]  MFR_ID = 8'hC3,   // Arbitrary value
  parameter logic [15:0] DEV_ID = 16'h1234 // Arbitrary value
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_cs_n,
  input  wire logic i_sclk,
  input  wire logic i_mosi,
  output logic      o_so,
  output logic      o_so_oe_n,
  output logic      o_soft_rst,
  output logic      o_lockdown
);
  spirc_pkg::spirc_regs_type q;
  spirc_pkg::spirc_regs_type d;

  logic [2:0] pins_s;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_start;
  logic       cs_end;
  logic       mosi_s;
  logic [7:0] in_byte;
  logic       frame_done;

  // Select travels inverted so the synchroniser's cleared state means idle, not a false frame
  spirc_sync #(
    .WIDTH (3)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async ({~i_cs_n, i_sclk, i_mosi}),
    .o_sync  (pins_s)
  );

  spirc_link_edges u_edges (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_sclk_s   (pins_s[1]),
    .i_cs_n_s   (~pins_s[2]),
    .o_rise     (sclk_rise),
    .o_fall     (sclk_fall),
    .o_cs_start (cs_start),
    .o_cs_end   (cs_end)
  );

  assign mosi_s  = pins_s[0];
  assign in_byte = {q.shreg[6:0], mosi_s};

  // Address bytes that follow each opcode
  function automatic logic [2:0] addr_bytes(input logic [7:0] op);
    case (op)
      `SPIRC_OP_PT_RD:  addr_bytes = `SPIRC_PT_ADDR_BYTES;
      `SPIRC_OP_CR2_RD,
      `SPIRC_OP_CR2_WR: addr_bytes = `SPIRC_CR2_ADDR_BYTES;
      default:          addr_bytes = 3'd0;
    endcase
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    case (op)
      `SPIRC_OP_ID_RD, `SPIRC_OP_PT_RD, `SPIRC_OP_SR_RD, `SPIRC_OP_CR_RD, `SPIRC_OP_CR2_RD,
      `SPIRC_OP_FB_RD, `SPIRC_OP_SEC_RD, `SPIRC_OP_LOCK_RD: is_read = 1'b1;
      default: is_read = 1'b0;
    endcase
  endfunction

  function automatic logic is_write(input logic [7:0] op);
    case (op)
      `SPIRC_OP_SRCR_WR, `SPIRC_OP_CR2_WR, `SPIRC_OP_FB_WR, `SPIRC_OP_LOCK_WR: is_write = 1'b1;
      default: is_write = 1'b0;
    endcase
  endfunction

  // Parameter table contents; unpopulated locations read as erased
  function automatic logic [7:0] table_byte(input logic [7:0] a);
    case (a)
      8'h00:   table_byte = 8'h53;
      8'h01:   table_byte = 8'h46;
      8'h02:   table_byte = 8'h44;
      8'h03:   table_byte = 8'h50;
      default: table_byte = 8'hFF;
    endcase
  endfunction

  // Byte number idx of the answer to a read opcode
  function automatic logic [7:0] rd_byte(input logic [7:0] op, input logic [2:0] idx,
                                         input spirc_pkg::spirc_regs_type r);
    case (op)
      `SPIRC_OP_ID_RD: begin
        case (idx)
          3'd0:    rd_byte = MFR_ID;
          3'd1:    rd_byte = DEV_ID[15:8];
          3'd2:    rd_byte = DEV_ID[7:0];
          default: rd_byte = 8'h00;
        endcase
      end
      `SPIRC_OP_PT_RD:   rd_byte = table_byte(r.addr[7:0] + {5'h00, idx});
      `SPIRC_OP_SR_RD:   rd_byte = r.status;
      `SPIRC_OP_CR_RD:   rd_byte = r.cfg;
      `SPIRC_OP_CR2_RD:  rd_byte = r.cfg2[r.addr[`SPIRC_CR2_IDX_W-1:0]];
      `SPIRC_OP_FB_RD:   rd_byte = r.boot[{idx[1:0], 3'b000} +: 8];
      `SPIRC_OP_SEC_RD:  rd_byte = r.secur;
      `SPIRC_OP_LOCK_RD: rd_byte = r.lock;
      default:           rd_byte = 8'h00;
    endcase
  endfunction

  // Volatile registers and the sequencer return here on either reset
  function automatic spirc_pkg::spirc_regs_type soft_state(input spirc_pkg::spirc_regs_type r);
    spirc_pkg::spirc_regs_type s;
    s          = r;
    s.st       = spirc_pkg::ST_IDLE;
    s.armed    = 1'b0;
    s.so_oe_n  = 1'b1;
    s.status   = `SPIRC_SR_RST;
    s.cfg      = `SPIRC_CR_RST;
    s.cfg2     = {`SPIRC_CR2_DEPTH{`SPIRC_CR2_RST}};
    s.lock     = `SPIRC_LOCK_RST;
    return s;
  endfunction

  assign frame_done = (q.st != spirc_pkg::ST_IDLE) && (q.st != spirc_pkg::ST_OPCODE);

  always_comb begin
    d          = q;
    d.soft_rst = 1'b0;
    if (i_rst) begin
      d        = '0;
      d        = soft_state(d);
      d.boot   = `SPIRC_FB_ERASED;
      d.secur  = `SPIRC_SEC_RST;
    end else if (cs_end) begin
      d.st      = spirc_pkg::ST_IDLE;
      d.so_oe_n = 1'b1;
      if (frame_done) begin
        d.armed = (q.op == `SPIRC_OP_RST_ARM);
        case (q.op)
          `SPIRC_OP_RST: begin
            if (q.armed) begin
              d          = soft_state(q);
              d.soft_rst = 1'b1;
            end
          end
          `SPIRC_OP_SRCR_WR: begin
            if (q.byte_cnt == 3'd1) begin
              d.status = q.stage[7:0];
            end else if (q.byte_cnt >= 3'd2) begin
              d.status = q.stage[15:8];
              d.cfg    = q.stage[7:0];
            end
          end
          `SPIRC_OP_CR2_WR: begin
            if (q.byte_cnt == 3'd1) begin
              d.cfg2[q.addr[`SPIRC_CR2_IDX_W-1:0]] = q.stage[7:0];
            end
          end
          `SPIRC_OP_FB_WR: begin
            // First byte sent lands in the low byte, matching read order
            if (q.byte_cnt == `SPIRC_FB_BYTES) begin
              d.boot = {q.stage[7:0], q.stage[15:8], q.stage[23:16], q.stage[31:24]};
            end
          end
          `SPIRC_OP_FB_ERASE: d.boot = `SPIRC_FB_ERASED;
          `SPIRC_OP_SEC_LOCK: d.secur[`SPIRC_SEC_LDSO_BIT] = 1'b1;
          `SPIRC_OP_LOCK_WR: begin
            if (q.byte_cnt == 3'd1) begin
              d.lock = q.stage[7:0];
            end
          end
          default: ;
        endcase
      end
    end else if (cs_start) begin
      d.st       = spirc_pkg::ST_OPCODE;
      d.bit_cnt  = 3'd0;
      d.byte_cnt = 3'd0;
      d.stage    = 32'h00000000;
      d.addr     = 32'h00000000;
      d.out_idx  = 3'd0;
      d.out_bit  = 3'd0;
    end else if (sclk_rise) begin
      d.shreg   = in_byte;
      d.bit_cnt = q.bit_cnt + 3'd1;
      if (q.bit_cnt == 3'd7) begin
        case (q.st)
          spirc_pkg::ST_OPCODE: begin
            d.op        = in_byte;
            d.addr_left = addr_bytes(in_byte);
            if (addr_bytes(in_byte) != 3'd0) begin
              d.st = spirc_pkg::ST_ADDR;
            end else if (is_read(in_byte)) begin
              d.st     = spirc_pkg::ST_DOUT;
              d.out_sh = rd_byte(in_byte, 3'd0, q);
            end else if (is_write(in_byte)) begin
              d.st = spirc_pkg::ST_DIN;
            end else begin
              d.st = spirc_pkg::ST_IGNORE;
            end
          end
          spirc_pkg::ST_ADDR: begin
            d.addr      = {q.addr[23:0], in_byte};
            d.addr_left = q.addr_left - 3'd1;
            if (q.addr_left == 3'd1) begin
              if (is_read(q.op)) begin
                d.st     = spirc_pkg::ST_DOUT;
                d.out_sh = rd_byte(q.op, 3'd0, d);
              end else begin
                d.st = spirc_pkg::ST_DIN;
              end
            end
          end
          spirc_pkg::ST_DIN: begin
            d.stage = {q.stage[23:0], in_byte};
            if (q.byte_cnt != 3'd7) begin
              d.byte_cnt = q.byte_cnt + 3'd1;
            end
          end
          default: ;
        endcase
      end
    end else if (sclk_fall && q.st == spirc_pkg::ST_DOUT) begin
      // Data changes on the falling edge so the host samples on the rising one
      d.so      = q.out_sh[7];
      d.so_oe_n = 1'b0;
      d.out_bit = q.out_bit + 3'd1;
      if (q.out_bit == 3'd7) begin
        d.out_idx = q.out_idx + 3'd1;
        d.out_sh  = rd_byte(q.op, q.out_idx + 3'd1, q);
      end else begin
        d.out_sh = {q.out_sh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    q <= d;
  end

  assign o_so       = q.so;
  assign o_so_oe_n  = q.so_oe_n;
  assign o_soft_rst = q.soft_rst;
  assign o_lockdown = q.secur[`SPIRC_SEC_LDSO_BIT];

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_nop_keeps_regs: assert property (cs_end && frame_done && q.op == `SPIRC_OP_NOP |=>
    $stable(q.status) && $stable(q.cfg) && $stable(q.cfg2) && $stable(q.boot) && $stable(q.lock))
    else $error("no-operation changed a register");
  a_rst_armed_only: assert property (cs_end && frame_done && q.op == `SPIRC_OP_RST && !q.armed |=>
    !q.soft_rst && $stable(q.status))
    else $error("reset acted without a preceding arm");
  a_rst_restores: assert property (cs_end && frame_done && q.op == `SPIRC_OP_RST && q.armed |=>
    q.soft_rst && q.status == `SPIRC_SR_RST && q.cfg == `SPIRC_CR_RST && !q.armed)
    else $error("armed reset did not restore registers");
  a_lockdown_sticky: assert property ($past(q.secur[`SPIRC_SEC_LDSO_BIT]) && !$past(i_rst) |->
    q.secur[`SPIRC_SEC_LDSO_BIT])
    else $error("lock-down bit was cleared");
  a_lockdown_sets: assert property (cs_end && frame_done && q.op == `SPIRC_OP_SEC_LOCK |=> o_lockdown)
    else $error("lock-down command did not set the bit");
  a_boot_erase: assert property (cs_end && frame_done && q.op == `SPIRC_OP_FB_ERASE |=>
    q.boot == `SPIRC_FB_ERASED)
    else $error("fast-boot erase failed");
  a_boot_exact_four: assert property (cs_end && q.op == `SPIRC_OP_FB_WR && q.byte_cnt != `SPIRC_FB_BYTES |=>
    $stable(q.boot))
    else $error("fast-boot written with wrong byte count");
  a_status_write: assert property (cs_end && frame_done && q.op == `SPIRC_OP_SRCR_WR && q.byte_cnt == 3'd1 |=>
    q.status == $past(q.stage[7:0]) && $stable(q.cfg))
    else $error("status write stored the wrong value");
  a_ignore_quiet: assert property (q.st == spirc_pkg::ST_IGNORE |-> o_so_oe_n)
    else $error("output driven during an ignored command");
  a_release_stops: assert property (cs_end |=> o_so_oe_n && q.st == spirc_pkg::ST_IDLE)
    else $error("output still driven after chip select release");
  a_drive_on_fall: assert property (q.st == spirc_pkg::ST_DOUT && sclk_fall |=>
    !o_so_oe_n && o_so == $past(q.out_sh[7]))
    else $error("read bit not shifted out on falling edge");

  c_reset_pair: cover property (cs_end && frame_done && q.op == `SPIRC_OP_RST && q.armed);
  c_id_read: cover property (q.op == `SPIRC_OP_ID_RD && q.out_idx == 3'd2 && sclk_fall);
  c_boot_write: cover property (cs_end && q.op == `SPIRC_OP_FB_WR && q.byte_cnt == `SPIRC_FB_BYTES);
  c_cfg2_write: cover property (cs_end && q.op == `SPIRC_OP_CR2_WR && q.byte_cnt == 3'd1);
endmodule

/* rtl/spirc_defines.svh */
// Opcodes, reset values and field positions of the serial register command decoder
`ifndef SPIRC_DEFINES_SVH
`define SPIRC_DEFINES_SVH

`define SPIRC_OP_NOP        8'h00
`define SPIRC_OP_RST_ARM    8'h66
`define SPIRC_OP_RST        8'h99
`define SPIRC_OP_ID_RD      8'h9F
`define SPIRC_OP_PT_RD      8'h5A
`define SPIRC_OP_SR_RD      8'h05
`define SPIRC_OP_CR_RD      8'h15
`define SPIRC_OP_SRCR_WR    8'h01
`define SPIRC_OP_CR2_RD     8'h71
`define SPIRC_OP_CR2_WR     8'h72
`define SPIRC_OP_FB_RD      8'h16
`define SPIRC_OP_FB_WR      8'h17
`define SPIRC_OP_FB_ERASE   8'h18
`define SPIRC_OP_SEC_RD     8'h2B
`define SPIRC_OP_SEC_LOCK   8'h2F
`define SPIRC_OP_LOCK_WR    8'h2C
`define SPIRC_OP_LOCK_RD    8'h2D

`define SPIRC_PT_ADDR_BYTES  3'd3
`define SPIRC_CR2_ADDR_BYTES 3'd4
`define SPIRC_FB_BYTES       3'd4

`define SPIRC_CR2_DEPTH      8
`define SPIRC_CR2_IDX_W      3

`define SPIRC_SR_RST         8'h00
`define SPIRC_CR_RST         8'h00
`define SPIRC_CR2_RST        8'h00
`define SPIRC_LOCK_RST       8'h00
`define SPIRC_SEC_RST        8'h00
`define SPIRC_FB_ERASED      32'hFFFFFFFF
`define SPIRC_SEC_LDSO_BIT   1

`endif

/* rtl/spirc_pkg.sv */
// Types of the serial register command decoder
package spirc_pkg;
  `include "spirc_defines.svh"

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR   = 3'b010,
    ST_DIN    = 3'b011,
    ST_DOUT   = 3'b100,
    ST_IGNORE = 3'b101
  } spirc_state_type;

  typedef struct packed {
    spirc_state_type                    st;
    logic [7:0]                         op;
    logic [7:0]                         shreg;
    logic [2:0]                         bit_cnt;
    logic [2:0]                         addr_left;
    logic [31:0]                        addr;
    logic [2:0]                         byte_cnt;
    logic [31:0]                        stage;
    logic [7:0]                         out_sh;
    logic [2:0]                         out_bit;
    logic [2:0]                         out_idx;
    logic                               so;
    logic                               so_oe_n;
    logic                               soft_rst;
    logic                               armed;
    logic [7:0]                         status;
    logic [7:0]                         cfg;
    logic [`SPIRC_CR2_DEPTH-1:0][7:0]   cfg2;
    logic [31:0]                        boot;
    logic [7:0]                         secur;
    logic [7:0]                         lock;
  } spirc_regs_type;
endpackage

/* rtl/spirc_sync.sv */
// Two-stage synchroniser for pins from outside the clock domain
module spirc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

/* rtl/spirc_link_edges.sv */
// Finds serial clock edges and frame start and end on synchronised pins
module spirc_link_edges (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_sclk_s,
  input  wire logic i_cs_n_s,
  output logic      o_rise,
  output logic      o_fall,
  output logic      o_cs_start,
  output logic      o_cs_end
);
  logic sclk_q;
  logic cs_n_q;

  // Chip select idles high after reset so no false frame end is seen
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sclk_q <= i_sclk_s;
      cs_n_q <= i_cs_n_s;
    end
  end

  always_comb begin
    o_rise     = i_sclk_s & ~sclk_q & ~i_cs_n_s;
    o_fall     = ~i_sclk_s & sclk_q & ~i_cs_n_s;
    o_cs_start = ~i_cs_n_s & cs_n_q;
    o_cs_end   = i_cs_n_s & ~cs_n_q;
  end
endmodule

/* bench/spirc_host_model.sv */
// Host-side serial controller model that drives mode 0 frames
module spirc_host_model (
  input  wire logic i_so,
  input  wire logic i_so_oe_n,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_mosi
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5ns;
  int oe_bad;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
    oe_bad = 0;
  end
  // Sends nw bytes of w (MSB byte first) then clocks in nr bytes, right-justified in r
  // Clock stands still low between frames; data line toggles while unused
  task automatic frame(input logic [63:0] w, input int nw, input int nr, output logic [31:0] r);
    r = '0;
    o_cs_n = 1'b0;
    #(HALF);
    for (int i = 0; i < 8 * (nw + nr); i++) begin
      if (i < 8 * nw) o_mosi = w[63 - i];
      else o_mosi = ~o_mosi;
      #(HALF);
      o_sclk = 1'b1;
      if (i >= 8 * nw) begin
        if (i_so_oe_n !== 1'b0) oe_bad++;
        r = {r[30:0], i_so};
      end
      #(HALF);
      o_sclk = 1'b0;
    end
    #(HALF);
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    // Idle gap lets commits land and the output driver release
    #(4 * HALF);
  endtask
endmodule

/* bench/spirc_cmd_decoder_tb_top.sv */
// Self-checking bench of the serial register command decoder
module spirc_cmd_decoder_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0]  MFR = 8'h5E;    // Arbitrary value
  localparam logic [15:0] DEV = 16'hA17C; // Arbitrary value
  logic        i_clk;
  logic        i_rst;
  logic        cs_n;
  logic        sclk;
  logic        mosi;
  logic        so;
  logic        so_oe_n;
  logic        soft_rst;
  logic        lockdown;
  logic [31:0] r;
  logic [31:0] bt;
  logic [7:0]  a;
  logic [7:0]  b;
  logic [2:0]  idx;
  int          mismatches;
  int          check_count;
  int          pulses;
  int          st;
  int          cf;
  int          sc;
  int          lk;
  int          c2 [8];

  spirc_cmd_decoder #(.MFR_ID(MFR), .DEV_ID(DEV)) DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_mosi(mosi),
    .o_so(so), .o_so_oe_n(so_oe_n), .o_soft_rst(soft_rst), .o_lockdown(lockdown));
  spirc_host_model host (.i_so(so), .i_so_oe_n(so_oe_n), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));

  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) if (soft_rst === 1'b1) pulses++;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic op(input logic [7:0] code);
    host.frame({code, 56'h0}, 1, 0, r);
  endtask
  task automatic rd(input logic [7:0] code, input int nr, input logic [31:0] exp, input string name);
    host.frame({code, 56'h0}, 1, nr, r);
    chk(name, exp, r);
  endtask
  task automatic check_all();
    rd(8'h05, 1, st, "status");
    rd(8'h15, 1, cf, "config");
    rd(8'h2B, 1, sc, "security");
    rd(8'h2D, 1, lk, "lock");
    rd(8'h16, 4, {bt[7:0], bt[15:8], bt[23:16], bt[31:24]}, "boot");
    for (int i = 0; i < 8; i++) begin
      host.frame({8'h71, 29'h0, i[2:0], 24'h0}, 5, 1, r);
      chk("config2", c2[i], r);
    end
    chk("lockdown", sc[1], lockdown);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #900us;
    mismatches++;
    $display("mismatch watchdog expected done seen timeout");
    wrap_up();
  end

  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    mismatches = 0;
    check_count = 0;
    pulses = 0;
    st = 0;
    cf = 0;
    sc = 0;
    lk = 0;
    c2 = '{default: 0};
    bt = 32'hFFFFFFFF;
    void'($urandom(32'h527E2096));
    repeat (2) @(posedge i_clk);
    #1 i_rst = 1'b0;
    repeat (3) @(posedge i_clk);
    check_all();
    rd(8'h9F, 3, {8'h00, MFR, DEV}, "ident");
    host.frame({8'h5A, 24'h000001, 32'h0}, 4, 4, r);
    chk("table", 32'h464450FF, r);
    repeat (3) begin
      a = 8'($urandom);
      b = 8'($urandom);
      host.frame({8'h01, a, b, 40'h0}, 3, 0, r);
      st = a;
      cf = b;
      a = 8'($urandom);
      host.frame({8'h01, a, 48'h0}, 2, 0, r);
      st = a;
      idx = 3'($urandom_range(7));
      host.frame({8'h72, 29'h0, idx, b, 16'h0}, 6, 0, r);
      c2[idx] = b;
      host.frame({8'h2C, a, 48'h0}, 2, 0, r);
      lk = a;
      bt = $urandom;
      host.frame({8'h17, bt[7:0], bt[15:8], bt[23:16], bt[31:24], 24'h0}, 5, 0, r);
      // Short write must be refused
      host.frame({8'h17, 24'hABCDEF, 32'h0}, 4, 0, r);
      host.frame({8'hA7, 8'h01, 8'h55, 40'h0}, 3, 0, r);
      op(8'h00);
      check_all();
    end
    op(8'h18);
    bt = 32'hFFFFFFFF;
    check_all();
    op(8'h66);
    op(8'h00);
    op(8'h99);
    op(8'h99);
    chk("pulses", 0, pulses);
    check_all();
    op(8'h2F);
    sc = 2;
    op(8'h66);
    op(8'h99);
    chk("pulses", 1, pulses);
    st = 0;
    cf = 0;
    lk = 0;
    c2 = '{default: 0};
    check_all();
    chk("oe_bad", 0, host.oe_bad);
    wrap_up();
  end
endmodule
